//--- bstl_pkg.sv
// Constants shared by the stream link host controller
package bstl_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned TICK_MAX_NS   = 500;
    localparam int unsigned TICK_MAX_CYC  = (TICK_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned STREAMS       = 32;
    localparam int unsigned KW            = 3;
    localparam logic        DIR_FORWARD   = 1'b1;
    localparam logic        DIR_REVERSE   = 1'b0;
    localparam logic        IDLE_LEVEL    = 1'b1;
    typedef enum logic [1:0] {BSTL_IDLE, BSTL_ALIGN, BSTL_RUN} bstl_state_t;
endpackage

//--- bstl_host.sv
// Host controller: drives a stream input module (acquisition side)
module bstl_host #(
    parameter int unsigned STREAMS      = bstl_pkg::STREAMS,
    parameter int unsigned CLK_DIV      = 6,
    parameter int unsigned TICK_CYCLES  = 4,
    parameter bit          REV_FITTED   = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 user_tick,
    input  wire logic                 user_enable,
    input  wire logic                 user_reverse_req,
    input  wire logic [bstl_pkg::KW-1:0] user_k,
    input  wire logic [STREAMS-1:0]   user_data,
    output logic                      user_data_ready,
    output logic                      user_ack_tick,
    output logic                      input_clock,
    output logic                      second_tick,
    output logic [STREAMS-1:0]        input_stream,
    output logic                      input_valid,
    output logic                      input_direction_ctrl,
    output logic                      input_spare_a_out,
    output logic                      input_spare_a_oe_n,
    input  wire logic                 input_spare_a_in,
    output logic                      input_spare_b_out,
    output logic                      input_spare_b_oe_n,
    input  wire logic                 input_spare_b_in,
    output logic                      pattern_gen_control,
    output logic                      record_time_tick,
    output logic                      reverse_active
);
    localparam int unsigned DW = $clog2(CLK_DIV) + 1;
    localparam int unsigned TW = $clog2(TICK_CYCLES * CLK_DIV + 1) + 1;
    logic [DW-1:0] div_cnt;
    logic          clk_fall;
    logic          clk_rise;
    logic [TW-1:0] tick_cnt;
    logic [7:0]    samp_cnt;
    logic [7:0]    samp_mask;
    logic          sample_slot;
    logic          first_post_tick_sample;
    logic          tick_req;
    logic          a_s1, a_s2, b_s1, b_s2;
    logic          b_prev;
    logic          spare_rev;
    bstl_pkg::bstl_state_t state;
    bstl_pkg::bstl_state_t next_state;

    // Link clock divider, changes on falling edge half
    assign clk_rise = (div_cnt == DW'(CLK_DIV - 1));
    assign clk_fall = (div_cnt == DW'(CLK_DIV / 2 - 1));
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt     <= '0;
            input_clock <= 1'b0;
        end else begin
            div_cnt <= clk_rise ? '0 : div_cnt + DW'(1);
            if (clk_rise)
                input_clock <= 1'b1;
            else if (clk_fall)
                input_clock <= 1'b0;
        end
    end

    // Tick pulse width held between one link cycle and the limit
    // Request is latched; a second request before issue merges with it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_req    <= 1'b0;
            tick_cnt    <= '0;
            second_tick <= 1'b0;
        end else begin
            if (user_tick && user_enable)
                tick_req <= 1'b1;
            if (clk_fall && tick_req && tick_cnt == '0) begin
                second_tick <= 1'b1;
                tick_cnt    <= TW'(TICK_CYCLES * CLK_DIV);
                tick_req    <= 1'b0;
            end else if (tick_cnt != '0) begin
                tick_cnt <= tick_cnt - TW'(1);
                if (tick_cnt == TW'(1))
                    second_tick <= 1'b0;
            end
        end
    end

    // Sample slots: first one link cycle after the tick rise for every k,
    // then every 2^k link cycles counted from that first slot
    assign first_post_tick_sample = clk_fall && second_tick
                                    && (tick_cnt > TW'((TICK_CYCLES - 1) * CLK_DIV));
    assign samp_mask   = 8'((16'h0001 << user_k) - 16'h0001);
    assign sample_slot = first_post_tick_sample
                         || (clk_fall && ((samp_cnt & samp_mask) == 8'h00));
    always_comb begin
        next_state = state;
        case (state)
            bstl_pkg::BSTL_IDLE:  if (user_enable) next_state = bstl_pkg::BSTL_ALIGN;
            bstl_pkg::BSTL_ALIGN: if (second_tick && clk_fall) next_state = bstl_pkg::BSTL_RUN;
            bstl_pkg::BSTL_RUN:   if (!user_enable) next_state = bstl_pkg::BSTL_IDLE;
            default:              next_state = bstl_pkg::BSTL_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= bstl_pkg::BSTL_IDLE;
            samp_cnt     <= '0;
            input_stream <= '0;
            input_valid  <= 1'b0;
        end else begin
            state <= next_state;
            if (first_post_tick_sample)
                samp_cnt <= 8'h01;
            else if (clk_fall)
                samp_cnt <= samp_cnt + 8'h01;
            if (sample_slot && state != bstl_pkg::BSTL_IDLE)
                input_stream <= user_data;
            input_valid <= (state == bstl_pkg::BSTL_RUN);
        end
    end
    assign user_data_ready = sample_slot && state != bstl_pkg::BSTL_IDLE;
    assign user_ack_tick   = tick_req;

    // Direction control and spare lines
    assign spare_rev = REV_FITTED && user_reverse_req;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_direction_ctrl <= bstl_pkg::DIR_FORWARD;
            reverse_active       <= 1'b0;
        end else begin
            input_direction_ctrl <= spare_rev ? bstl_pkg::DIR_REVERSE
                                              : bstl_pkg::DIR_FORWARD;
            reverse_active       <= !input_direction_ctrl;
        end
    end
    // Spares driven only while forward; released when reversed
    assign input_spare_a_oe_n = reverse_active || !input_direction_ctrl;
    assign input_spare_b_oe_n = reverse_active || !input_direction_ctrl;
    assign input_spare_a_out  = bstl_pkg::IDLE_LEVEL;
    assign input_spare_b_out  = bstl_pkg::IDLE_LEVEL;

    // Reverse spares cross into clk domain
    // Reset to the pull-up level so no false edge follows reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            a_s1 <= bstl_pkg::IDLE_LEVEL;
            a_s2 <= bstl_pkg::IDLE_LEVEL;
            b_s1 <= bstl_pkg::IDLE_LEVEL;
            b_s2 <= bstl_pkg::IDLE_LEVEL;
            b_prev <= bstl_pkg::IDLE_LEVEL;
            pattern_gen_control <= 1'b0;
            record_time_tick    <= 1'b0;
        end else begin
            a_s1 <= input_spare_a_in;
            a_s2 <= a_s1;
            b_s1 <= input_spare_b_in;
            b_s2 <= b_s1;
            b_prev <= b_s2;
            pattern_gen_control <= reverse_active && a_s2;
            record_time_tick    <= reverse_active && b_s2 && !b_prev;
        end
    end

    // Checks on the host side of the link
    chk_dir_default: assert property (@(posedge clk) disable iff (sys_rst)
        !spare_rev |=> input_direction_ctrl)
        else $error("direction not forward");
    chk_spare_release: assert property (@(posedge clk) disable iff (sys_rst)
        !input_direction_ctrl |-> input_spare_a_oe_n && input_spare_b_oe_n)
        else $error("spare driven while reversed");
    chk_fwd_drive: assert property (@(posedge clk) disable iff (sys_rst)
        input_direction_ctrl && $past(input_direction_ctrl) && !reverse_active
        |-> !input_spare_a_oe_n)
        else $error("spare not driven forward");
    chk_tick_width: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(second_tick) |-> second_tick [*6])
        else $error("tick too short");
    chk_tick_max: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(second_tick) |-> ##[1:50] !second_tick)
        else $error("tick too long");
    chk_rev_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        !input_direction_ctrl |-> $past(spare_rev))
        else $error("reverse without command");
    chk_valid_run: assert property (@(posedge clk) disable iff (sys_rst)
        input_valid |-> $past(state) == bstl_pkg::BSTL_RUN)
        else $error("valid outside run");
    chk_rec_tick: assert property (@(posedge clk) disable iff (sys_rst)
        record_time_tick |-> $past(reverse_active))
        else $error("record tick while forward");
    chk_first_post_tick_sample_offset: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(second_tick) |-> ##5 first_post_tick_sample)
        else $error("first sample not one link cycle after tick");
    chk_tick_issue: assert property (@(posedge clk) disable iff (sys_rst)
        user_ack_tick && clk_fall && tick_cnt == TW'(0) |=> $rose(second_tick))
        else $error("pending tick not issued");
    // One released cycle when forward returns, so both ends never drive a spare
    chk_turn_guard: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(input_direction_ctrl) |-> input_spare_a_oe_n && input_spare_b_oe_n)
        else $error("spare driven without guard cycle");
    chk_rev_outputs: assert property (@(posedge clk) disable iff (sys_rst)
        !reverse_active |=> !pattern_gen_control && !record_time_tick)
        else $error("reverse output while forward");
    cov_first_post_tick_sample: cover property (@(posedge clk) first_post_tick_sample);
    cov_tick: cover property (@(posedge clk) $rose(second_tick));
    cov_run: cover property (@(posedge clk) state == bstl_pkg::BSTL_RUN);
    cov_rev: cover property (@(posedge clk) reverse_active);
endmodule

//--- bstl_dev_model.sv
// Behavioural input module facing the host controller
module bstl_dev_model #(
    parameter int MON_CYC = 40
) (
    input  wire logic clk,
    input  wire logic second_tick,
    input  wire logic ctrl,
    input  wire logic a_out,
    input  wire logic a_oe_n,
    input  wire logic b_out,
    input  wire logic b_oe_n,
    input  wire logic rev_a,
    input  wire logic rev_b,
    output logic      a_line,
    output logic      b_line,
    output int        tick_len,
    output logic      mon
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    int   mon_cnt = 0;
    logic tick_prev = 1'b0;
    // Reverse drive only while commanded, else released to pull-up level
    assign a_line = !a_oe_n ? a_out : (ctrl == bstl_pkg::DIR_REVERSE ? rev_a : 1'b1);
    assign b_line = !b_oe_n ? b_out : (ctrl == bstl_pkg::DIR_REVERSE ? rev_b : 1'b1);
    // Tick seen high in own clock; width of last pulse kept
    always @(posedge clk) begin
        if (second_tick) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            tick_len <= cnt;
            cnt      <= 0;
        end
    end
    // Monitor stretched from each tick rise, rising one clk cycle after it
    always @(posedge clk) begin
        tick_prev <= second_tick;
        if (second_tick && !tick_prev)
            mon_cnt <= MON_CYC;
        else if (mon_cnt != 0)
            mon_cnt <= mon_cnt - 1;
    end
    assign mon = (mon_cnt != 0);
endmodule

//--- bstl_host_tb_top.sv
// Self-checking bench for the stream link host controller
module bstl_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LINK_DIV = 6;
    localparam int unsigned TICK_LEN = 24;
    logic clk = 0, sys_rst = 1, tick = 0, en = 0, rev = 0, rev_a = 0, rev_b = 0;
    logic [2:0] k = 3'h1;
    logic [31:0] data = 32'h0000_0000;
    logic rdy, ack, iclk, stk, valid, ctrl, a_o, a_oe, b_o, b_oe, a_ln, b_ln, pgc, rtt, ract, mon;
    logic [31:0] strm;
    int tick_len, err_count = 0, n_compared = 0, t0;
    bstl_host bstl_host_inst (.clk(clk), .sys_rst(sys_rst), .user_tick(tick),
        .user_enable(en), .user_reverse_req(rev), .user_k(k), .user_data(data),
        .user_data_ready(rdy), .user_ack_tick(ack), .input_clock(iclk), .second_tick(stk),
        .input_stream(strm), .input_valid(valid), .input_direction_ctrl(ctrl),
        .input_spare_a_out(a_o), .input_spare_a_oe_n(a_oe), .input_spare_a_in(a_ln),
        .input_spare_b_out(b_o), .input_spare_b_oe_n(b_oe), .input_spare_b_in(b_ln),
        .pattern_gen_control(pgc), .record_time_tick(rtt), .reverse_active(ract));
    bstl_dev_model bstl_dev_model_inst (.clk(clk), .second_tick(stk), .ctrl(ctrl),
        .a_out(a_o), .a_oe_n(a_oe), .b_out(b_o), .b_oe_n(b_oe), .rev_a(rev_a),
        .rev_b(rev_b), .a_line(a_ln), .b_line(b_ln), .tick_len(tick_len), .mon(mon));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 400 && rdy !== 1'b1; i++) @(posedge clk) #1;
        if (i == 400) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic wait_tick(input logic lvl);
        int i;
        for (i = 0; i < 400 && stk !== lvl; i++) @(posedge clk) #1;
        if (i == 400) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic test_reset();
        chk("direction", bstl_pkg::DIR_FORWARD, ctrl);
        chk("valid", 1'b0, valid);
        chk("spare_a", 1'b1, a_ln);
        chk("spare a drive", 1'b0, a_oe);
        chk("link clock idle", 1'b0, iclk);
        chk("tick idle", 1'b0, stk);
        chk("reverse idle", 1'b0, ract);
        $display("test reset done");
    endtask
    task automatic test_tick_samples(input logic [2:0] kv, input logic [31:0] dv);
        @(posedge clk);
        k <= kv;
        en <= 1'b1;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1;
        chk("tick pending", 1'b1, ack);
        wait_tick(1'b1);
        t0 = $time;
        chk("tick taken", 1'b0, ack);
        @(posedge clk);
        data <= dv;
        #1;
        wait_rdy();
        @(posedge clk) #1;
        chk("first sample offset", LINK_DIV, 32'(($time - t0) / 10));
        chk("stream", dv, strm);
        chk("link clock at slot", 1'b0, iclk);
        chk("record monitor", 1'b1, mon);
        t0 = $time;
        wait_rdy();
        @(posedge clk) #1;
        chk("slot spacing", (32'h1 << kv) * LINK_DIV, 32'(($time - t0) / 10));
        wait_tick(1'b0);
        @(posedge clk) #1;
        chk("tick width", TICK_LEN, tick_len);
        chk("monitor stretched", 1'b1, mon);
        chk("valid run", 1'b1, valid);
        $display("test tick k=%0d done", kv);
    endtask
    task automatic test_reverse();
        @(posedge clk);
        rev <= 1'b1;
        rev_a <= 1'b0;
        rev_b <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("direction rev", bstl_pkg::DIR_REVERSE, ctrl);
        chk("spare a released", 1'b1, a_oe);
        chk("spare b released", 1'b1, b_oe);
        chk("reverse active", 1'b1, ract);
        chk("pattern ctrl low", 1'b0, pgc);
        chk("record tick idle", 1'b0, rtt);
        @(posedge clk);
        rev_a <= 1'b1;
        rev_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("pattern ctrl high", 1'b1, pgc);
        chk("record tick", 1'b1, rtt);
        @(posedge clk) #1;
        chk("record tick end", 1'b0, rtt);
        @(posedge clk);
        rev <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("direction back", bstl_pkg::DIR_FORWARD, ctrl);
        chk("spare a driven", 1'b0, a_oe);
        chk("spare b driven", 1'b0, b_oe);
        chk("reverse ended", 1'b0, ract);
        chk("pattern ctrl fwd", 1'b0, pgc);
        $display("test reverse done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        test_reset();
        test_tick_samples(3'h0, 32'ha5c3_0f01);
        test_tick_samples(3'h2, 32'h5a3c_f0e1);
        test_reverse();
        give_verdict();
    end
endmodule
